// >>> shared/sysctl_pkg.sv
// Package for the system control register block.
// Assumes a 32-bit word-aligned main-bus register port on sys_clk.
package sysctl_pkg;
	// ==========================================================
	// Register addresses (400 station map and 300 station map)
	localparam logic [31:0] ADDR_DIAG_CONTROL     = 32'hFFF840C0;
	localparam logic [31:0] ADDR_DIAG_STATUS      = 32'hFFF840C4;
	localparam logic [31:0] ADDR_PARITY_ERR       = 32'hFFF840C8;
	localparam logic [31:0] ADDR_DIAG_CONTROL_S   = 32'hFFF84008;
	localparam logic [31:0] ADDR_DIAG_STATUS_S    = 32'hFFF8400C;
	localparam logic [31:0] ADDR_PARITY_ERR_S     = 32'hFFF84010;
	localparam logic [31:0] ADDR_VME_UPPER        = 32'hFFF88010;
	localparam logic [31:0] ADDR_CPU_CONFIG       = 32'hFFF88018;
	// ==========================================================
	// Diagnostic control field positions
	localparam int BIT_BOARD_RESET   = 0;
	localparam int BIT_DISK_RESET_N  = 1;
	localparam int BIT_LAN_RESET_N   = 2;
	localparam int BIT_IO_RESET_N    = 3;
	localparam int BIT_FORCE_PARITY  = 4;
	localparam int BIT_UTIL_HIGH     = 5;
	localparam int BIT_KBD_RESET_N   = 6;
	localparam int BIT_LED_OFF       = 7;
	localparam int BIT_MONITOR_SEL   = 8;
	localparam int DIAG_CTRL_BITS    = 9;
	localparam logic [DIAG_CTRL_BITS-1:0] DIAG_CTRL_RESET = 9'h000;
	// ==========================================================
	// Address forming
	localparam int VME24_BITS     = 24;
	localparam int PAGE_OFS_BITS  = 22;
	localparam int UTIL_IGN_BITS  = 10;
	localparam logic [9:0] UTIL_HIGH_TOP = 10'h3FF;
	// VME address space select codes
	typedef enum logic [1:0]
	{
		SPACE_A32  = 2'b00,
		SPACE_A24  = 2'b01,
		SPACE_A16  = 2'b10,
		SPACE_NONE = 2'b11
	} vme_space_t;
	// Access type from modifier bits 3..0
	typedef enum logic [2:0]
	{
		ACC_SUP_BLOCK  = 3'b000,
		ACC_SUP_PROG   = 3'b001,
		ACC_SUP_DATA   = 3'b010,
		ACC_USR_BLOCK  = 3'b011,
		ACC_USR_PROG   = 3'b100,
		ACC_USR_DATA   = 3'b101,
		ACC_INVALID    = 3'b110
	} access_t;
endpackage

// >>> shared/vme_xlate_if.sv
// Interface between the register bank and the VME address translator.
// Assumes both ends run on sys_clk.
interface vme_xlate_if;
	import sysctl_pkg::*;
	logic [7:0]  upper_addr_field;
	logic        req;
	vme_space_t  space;
	logic [31:0] vme_addr;
	logic [3:0]  am;
	logic        grant;
	logic [31:0] mbus_addr;
	access_t     access;
	modport regs
	(
		output upper_addr_field,
		output req,
		output space,
		output vme_addr,
		output am,
		input  grant,
		input  mbus_addr,
		input  access
	);
	modport xlate
	(
		input  upper_addr_field,
		input  req,
		input  space,
		input  vme_addr,
		input  am,
		output grant,
		output mbus_addr,
		output access
	);
endinterface

// >>> rtl/vme_xlate.sv
// VME to main-bus address translator.
// Assumes requests are registered on sys_clk by the register bank.
module vme_xlate
	import sysctl_pkg::*;
(
	input  wire logic  sys_clk,
	input  wire logic  rst_n,
	vme_xlate_if.xlate x
);
	// ==========================================================
	// Decode of access type
	function automatic access_t decode_am(input logic [3:0] am);
		case (am)
			4'hF:    decode_am = ACC_SUP_BLOCK;
			4'hE:    decode_am = ACC_SUP_PROG;
			4'hD:    decode_am = ACC_SUP_DATA;
			4'hB:    decode_am = ACC_USR_BLOCK;
			4'hA:    decode_am = ACC_USR_PROG;
			4'h9:    decode_am = ACC_USR_DATA;
			default: decode_am = ACC_INVALID;
		endcase
	endfunction

	// Registered translation, one cycle after request
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			x.grant     <= 1'b0;
			x.mbus_addr <= 32'h00000000;
			x.access    <= ACC_INVALID;
		end
		else
		begin
			x.access <= decode_am(x.am);
			case (x.space)
				SPACE_A24:
				begin
					x.grant     <= x.req;
					x.mbus_addr <= {x.upper_addr_field,
						x.vme_addr[VME24_BITS-1:0]};
				end
				SPACE_A32:
				begin
					x.grant     <= x.req;
					x.mbus_addr <= {x.vme_addr[31:PAGE_OFS_BITS],
						x.vme_addr[PAGE_OFS_BITS-1:0]};
				end
				// Short-address masters never reach the board
				default:
				begin
					x.grant     <= 1'b0;
					x.mbus_addr <= 32'h00000000;
				end
			endcase
		end
	end

	property p_a16_blocked;
		@(posedge sys_clk) disable iff (!rst_n)
		(x.space == SPACE_A16) |=> !x.grant;
	endproperty
	a_a16_blocked: assert property (p_a16_blocked)
		else $error("short-address master granted");

	property p_a24_form;
		@(posedge sys_clk) disable iff (!rst_n)
		(x.req && x.space == SPACE_A24) |=> (x.grant &&
		x.mbus_addr == {$past(x.upper_addr_field), $past(x.vme_addr[23:0])});
	endproperty
	a_a24_form: assert property (p_a24_form)
		else $error("24-bit address formed wrongly");

	property p_a32_pass;
		@(posedge sys_clk) disable iff (!rst_n)
		(x.req && x.space == SPACE_A32) |=>
		(x.mbus_addr == $past(x.vme_addr));
	endproperty
	a_a32_pass: assert property (p_a32_pass)
		else $error("32-bit address not passed");

	property p_am_decode;
		@(posedge sys_clk) disable iff (!rst_n)
		(x.am == 4'h9) |=> (x.access == ACC_USR_DATA);
	endproperty
	a_am_decode: assert property (p_am_decode)
		else $error("modifier decode wrong");
endmodule

// >>> rtl/sysctl_regs.sv
// System control register bank with VME address extension.
// Assumes a 32-bit word main-bus register port on sys_clk and
// VME request signals already synchronous to sys_clk.
// ==========================================================
// How it works
// - Short-address VME masters never reach board
// - Upper register plus 24 VME bits
// - Modifier bits 3..0 give access type
// - 32-bit VME addresses pass as page+offset
// - Upper register write-only, eight bits
// - Resets never touch the upper register
// - Registers are full 32-bit word accesses
// - Diagnostic status read-only, both addresses
// - Parity address read-only, both addresses
// - Diagnostic control write-only, bits 15..9 unused
// - All control bits clear on reset
// - Bit 8 selects monitor rate
// - Bit 7 drives indicator inverted
// - Bit 6 low holds keyboard reset
// - Bit 5 high maps utility space top
// - Bit 5 low maps utility low, write-only
// - Bit 4 forces parity ones on writes
// - Bit 2 low holds network reset
// - Bit 0 one resets whole board
module sysctl_regs
	import sysctl_pkg::*;
#(
	parameter bit SMALL_STATION = 1'b0
)
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        reg_sel,
	input  wire logic        reg_write,
	input  wire logic [3:0]  reg_byte_en,
	input  wire logic [31:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	output logic [31:0]      reg_rdata,
	output logic             reg_ack,
	output logic             reg_error,
	input  wire logic [31:0] diag_status_in,
	input  wire logic [31:0] parity_err_in,
	input  wire logic [31:0] cpu_config_in,
	input  wire logic        vme_req,
	input  wire logic [1:0]  vme_space,
	input  wire logic [31:0] vme_addr,
	input  wire logic [3:0]  vme_am,
	output logic             vme_grant,
	output logic [31:0]      vme_mbus_addr,
	output logic [2:0]       vme_access,
	input  wire logic [31:0] util_addr,
	input  wire logic        util_write,
	output logic [31:0]      util_mem_addr,
	output logic             util_read_ok,
	output logic             util_hit,
	output logic [3:0]       mem_parity_force,
	output logic             monitor_rate_sel,
	output logic             diag_led_on,
	output logic             kbd_reset_n,
	output logic             io_sub_reset_n,
	output logic             lan_reset_n,
	output logic             disk_port_reset_n,
	output logic             board_reset_trigger
);
	// ==========================================================
	// Register state
	logic [DIAG_CTRL_BITS-1:0] diag_control_reg;
	logic [7:0]                vme_upper_addr_reg;
	logic [31:0]               status_sync1;
	logic [31:0]               status_sync2;
	logic [31:0]               parity_sync1;
	logic [31:0]               parity_err_addr_reg;
	logic [31:0]               config_sync1;
	logic [31:0]               cpu_config_reg;
	logic                      full_word;
	logic                      wr_en;
	logic                      rd_en;
	logic                      upper_loaded;

	vme_xlate_if xif ();

	// Address decode that both station maps share
	function automatic logic hit(input logic [31:0] a,
		input logic [31:0] small_a, input logic [31:0] large_a);
		hit = SMALL_STATION ? (a == small_a) : (a == large_a);
	endfunction

	// Only whole-word accesses are honoured
	assign full_word = (reg_byte_en == 4'hF);
	assign wr_en = reg_sel && reg_write && full_word;
	assign rd_en = reg_sel && !reg_write && full_word;

	// ==========================================================
	// Status inputs come from other logic; sync for safety
	always_ff @(posedge sys_clk)
	begin
		status_sync1        <= diag_status_in;
		status_sync2        <= status_sync1;
		parity_sync1        <= parity_err_in;
		parity_err_addr_reg <= parity_sync1;
		config_sync1        <= cpu_config_in;
		cpu_config_reg      <= config_sync1;
	end

	// Diagnostic control, cleared by every reset
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			diag_control_reg <= DIAG_CTRL_RESET;
		else if (wr_en && hit(reg_addr, ADDR_DIAG_CONTROL_S,
			ADDR_DIAG_CONTROL))
			diag_control_reg <= reg_wdata[DIAG_CTRL_BITS-1:0];
		else
			diag_control_reg[BIT_BOARD_RESET] <= 1'b0; // self-clearing
	end

	// Upper address register: deliberately outside reset so a board
	// reset keeps the VME window software set up at power-on
	always_ff @(posedge sys_clk)
	begin
		if (wr_en && reg_addr == ADDR_VME_UPPER)
		begin
			vme_upper_addr_reg <= reg_wdata[7:0];
			upper_loaded       <= 1'b1; // Reset check skips power-up X
		end
	end

	// ==========================================================
	// Register read and acknowledge
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			reg_rdata <= 32'h00000000;
			reg_ack   <= 1'b0;
			reg_error <= 1'b0;
		end
		else
		begin
			reg_ack   <= reg_sel;
			reg_error <= reg_sel && !full_word;
			reg_rdata <= 32'h00000000; // write-only reads give zero
			if (rd_en && hit(reg_addr, ADDR_DIAG_STATUS_S,
				ADDR_DIAG_STATUS))
				reg_rdata <= status_sync2;
			else if (rd_en && hit(reg_addr, ADDR_PARITY_ERR_S,
				ADDR_PARITY_ERR))
				reg_rdata <= parity_err_addr_reg;
			else if (rd_en && !SMALL_STATION &&
				reg_addr == ADDR_CPU_CONFIG)
				reg_rdata <= cpu_config_reg;
		end
	end

	// ==========================================================
	// Control outputs straight from flip-flops
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			monitor_rate_sel    <= 1'b0;
			diag_led_on         <= 1'b1;
			kbd_reset_n         <= 1'b0;
			io_sub_reset_n      <= 1'b0;
			lan_reset_n         <= 1'b0;
			disk_port_reset_n   <= 1'b0;
			board_reset_trigger <= 1'b0;
		end
		else
		begin
			monitor_rate_sel  <= diag_control_reg[BIT_MONITOR_SEL];
			diag_led_on       <= !diag_control_reg[BIT_LED_OFF];
			kbd_reset_n       <= diag_control_reg[BIT_KBD_RESET_N];
			io_sub_reset_n    <= diag_control_reg[BIT_IO_RESET_N];
			lan_reset_n       <= diag_control_reg[BIT_LAN_RESET_N];
			disk_port_reset_n <= diag_control_reg[BIT_DISK_RESET_N];
			board_reset_trigger <=
				diag_control_reg[BIT_BOARD_RESET];
		end
	end

	// Parity forcing applies to writes only; reads see normal parity
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			mem_parity_force <= 4'h0;
		else
			mem_parity_force <= (diag_control_reg[BIT_FORCE_PARITY]
				&& util_write) ? 4'hF : 4'h0;
	end

	// ==========================================================
	// Utility space mapping
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			util_hit      <= 1'b0;
			util_read_ok  <= 1'b0;
			util_mem_addr <= 32'h00000000;
		end
		else if (diag_control_reg[BIT_UTIL_HIGH])
		begin
			util_hit      <= (util_addr[31:22] == UTIL_HIGH_TOP);
			util_read_ok  <= 1'b1;
			util_mem_addr <= util_addr;
		end
		else
		begin
			// Top bits ignored; low window is write-only
			util_hit      <= 1'b1;
			util_read_ok  <= 1'b0;
			util_mem_addr <= {{UTIL_IGN_BITS{1'b0}},
				util_addr[31-UTIL_IGN_BITS:0]};
		end
	end

	// ==========================================================
	// VME request path; the processor must enable 24-bit masters
	// before they arrive, this block only translates
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			xif.req      <= 1'b0;
			xif.space    <= SPACE_NONE;
			xif.vme_addr <= 32'h00000000;
			xif.am       <= 4'h0;
		end
		else
		begin
			xif.req      <= vme_req;
			xif.space    <= vme_space_t'(vme_space);
			xif.vme_addr <= vme_addr;
			xif.am       <= vme_am;
		end
	end
	assign xif.upper_addr_field = vme_upper_addr_reg;

	vme_xlate u_xlate
	(
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.x       (xif)
	);

	// Registered outputs of the translator copied to ports
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			vme_grant     <= 1'b0;
			vme_mbus_addr <= 32'h00000000;
			vme_access    <= ACC_INVALID;
		end
		else
		begin
			vme_grant     <= xif.grant;
			vme_mbus_addr <= xif.mbus_addr;
			vme_access    <= xif.access;
		end
	end

	// ==========================================================
	// Checks
	property p_ctrl_reset;
		@(posedge sys_clk) !rst_n |=> (diag_control_reg == 9'h000);
	endproperty
	a_ctrl_reset: assert property (p_ctrl_reset)
		else $error("control not cleared by reset");

	property p_upper_kept;
		@(posedge sys_clk)
		(!rst_n && !wr_en && upper_loaded) |=>
		$stable(vme_upper_addr_reg);
	endproperty
	a_upper_kept: assert property (p_upper_kept)
		else $error("upper register changed by reset");

	property p_led_inverted;
		@(posedge sys_clk) disable iff (!rst_n)
		##1 diag_led_on == !$past(diag_control_reg[BIT_LED_OFF]);
	endproperty
	a_led_inverted: assert property (p_led_inverted)
		else $error("indicator polarity wrong");

	sequence s_trigger_write;
		wr_en && hit(reg_addr, ADDR_DIAG_CONTROL_S, ADDR_DIAG_CONTROL)
		&& reg_wdata[0];
	endsequence
	property p_board_reset;
		@(posedge sys_clk) disable iff (!rst_n)
		s_trigger_write |=> ##1 board_reset_trigger;
	endproperty
	a_board_reset: assert property (p_board_reset)
		else $error("board reset not raised");

	property p_low_util;
		@(posedge sys_clk) disable iff (!rst_n)
		!diag_control_reg[BIT_UTIL_HIGH] |=> !util_read_ok;
	endproperty
	a_low_util: assert property (p_low_util)
		else $error("low utility space readable");

	property p_parity;
		@(posedge sys_clk) disable iff (!rst_n)
		(diag_control_reg[BIT_FORCE_PARITY] && util_write) |=>
		(mem_parity_force == 4'hF);
	endproperty
	a_parity: assert property (p_parity)
		else $error("parity ones not forced");

	property p_wo_read;
		@(posedge sys_clk) disable iff (!rst_n)
		(rd_en && reg_addr == ADDR_VME_UPPER) |=> (reg_rdata == 32'h0);
	endproperty
	a_wo_read: assert property (p_wo_read)
		else $error("write-only register returned data");

	property p_kbd;
		@(posedge sys_clk) disable iff (!rst_n)
		!diag_control_reg[BIT_KBD_RESET_N] |=> !kbd_reset_n;
	endproperty
	a_kbd: assert property (p_kbd)
		else $error("keyboard not held in reset");
endmodule

// >>> verification/vme_master_model.sv
// Behavioural VME master on the far side of the address path.
// Assumes sys_clk from the bench; the bench calls access().
// No reset input: it keeps its own state through board resets
module vme_master_model
	import sysctl_pkg::*;
(
	input  wire logic  sys_clk,
	output logic       vme_req,
	output logic [1:0] vme_space,
	output logic [31:0] vme_addr,
	output logic [3:0] vme_am
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Idle lines at time zero
	initial
	begin
		vme_req = 1'b0;
		vme_space = SPACE_NONE;
		vme_addr = 32'h0;
		vme_am = 4'h0;
	end
	// ==========================================================
	// One-cycle request; address and modifier lines then carry the inverse so a stale
	// address can never pass for a fresh one.
	// Called only once the processor has opened the window
	task automatic access(input logic [1:0] sp, input logic [31:0] a,
		input logic [3:0] m);
		@(posedge sys_clk);
		vme_req <= 1'b1;
		vme_space <= sp;
		vme_addr <= a;
		vme_am <= m;
		@(posedge sys_clk);
		vme_req <= 1'b0;
		vme_space <= SPACE_NONE;
		vme_addr <= ~a;
		vme_am <= ~m;
	endtask
endmodule

// >>> verification/test_sysctl_regs.sv
// Self-checking bench for the system control register bank.
// Assumes the design package and a VME master model alongside.
module test_sysctl_regs
	import sysctl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Signals
	logic sys_clk, rst_n, reg_sel, reg_write, reg_ack, reg_error;
	logic [3:0] reg_byte_en, vme_am, mem_parity_force;
	logic [31:0] reg_addr, reg_wdata, reg_rdata, vme_addr, util_addr;
	logic [31:0] vme_mbus_addr, util_mem_addr, rd, rdata_small, rds;
	logic kbd_small;
	logic vme_req, vme_grant, util_write, util_read_ok, util_hit;
	logic [1:0] vme_space;
	logic [2:0] vme_access;
	logic monitor_rate_sel, diag_led_on, kbd_reset_n, io_sub_reset_n;
	logic lan_reset_n, disk_port_reset_n, board_reset_trigger, er;
	int n_fail, n_tests, cycles, k;
	logic [31:0] ra [9];
	logic [31:0] rx [9];
	logic [31:0] rs [9];
	// ==========================================================
	// Design and far-side model
	sysctl_regs #(.SMALL_STATION(1'b0)) i_sysctl_regs (.sys_clk(sys_clk),
		.rst_n(rst_n), .reg_sel(reg_sel), .reg_write(reg_write),
		.reg_byte_en(reg_byte_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
		.reg_error(reg_error), .diag_status_in(32'h12345678),
		.parity_err_in(32'h0BAD0C40), .cpu_config_in(32'h5A5A0003),
		.vme_req(vme_req), .vme_space(vme_space), .vme_addr(vme_addr),
		.vme_am(vme_am), .vme_grant(vme_grant),
		.vme_mbus_addr(vme_mbus_addr), .vme_access(vme_access),
		.util_addr(util_addr), .util_write(util_write),
		.util_mem_addr(util_mem_addr), .util_read_ok(util_read_ok),
		.util_hit(util_hit), .mem_parity_force(mem_parity_force),
		.monitor_rate_sel(monitor_rate_sel), .diag_led_on(diag_led_on),
		.kbd_reset_n(kbd_reset_n), .io_sub_reset_n(io_sub_reset_n),
		.lan_reset_n(lan_reset_n), .disk_port_reset_n(disk_port_reset_n),
		.board_reset_trigger(board_reset_trigger));
	vme_master_model i_vme_master_model (.sys_clk(sys_clk),
		.vme_req(vme_req), .vme_space(vme_space), .vme_addr(vme_addr),
		.vme_am(vme_am));
	// Smaller-station map on the same bus; only read data and one
	// control pin are watched
	sysctl_regs #(.SMALL_STATION(1'b1)) i_sysctl_regs_small
		(.sys_clk(sys_clk), .rst_n(rst_n), .reg_sel(reg_sel),
		.reg_write(reg_write), .reg_byte_en(reg_byte_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(rdata_small), .reg_ack(), .reg_error(),
		.diag_status_in(32'h12345678), .parity_err_in(32'h0BAD0C40),
		.cpu_config_in(32'h5A5A0003), .vme_req(vme_req),
		.vme_space(vme_space), .vme_addr(vme_addr), .vme_am(vme_am),
		.vme_grant(), .vme_mbus_addr(), .vme_access(),
		.util_addr(util_addr), .util_write(util_write),
		.util_mem_addr(), .util_read_ok(), .util_hit(),
		.mem_parity_force(), .monitor_rate_sel(), .diag_led_on(),
		.kbd_reset_n(kbd_small), .io_sub_reset_n(), .lan_reset_n(),
		.disk_port_reset_n(), .board_reset_trigger());
	// ==========================================================
	// Clock and hang guard; 3000 cycles is ample for this run
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			n_fail = n_fail + 1;
			final_report();
		end
	end
	// ==========================================================
	// Tasks
	task automatic check(input string n, input logic [31:0] s, e);
		n_tests = n_tests + 1;
		if (s !== e)
		begin
			$display("[FAIL] %s expected %h seen %h", n, e, s);
			n_fail = n_fail + 1;
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, d,
		input logic [3:0] be);
		@(posedge sys_clk);
		reg_sel <= 1'b1;
		reg_write <= w;
		reg_addr <= a;
		reg_wdata <= d;
		reg_byte_en <= be;
		@(posedge sys_clk);
		reg_sel <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		#1;
		check("ack", {31'h0, reg_ack}, 32'h1);
		rd = reg_rdata;
		rds = rdata_small;
		er = reg_error;
	endtask
	// Control pins one cycle after the ack
	task automatic ctl(input logic [8:0] v);
		@(posedge sys_clk);
		#1;
		check("ctl", {26'h0, monitor_rate_sel, diag_led_on, kbd_reset_n,
			io_sub_reset_n, lan_reset_n, disk_port_reset_n},
			{26'h0, v[8], ~v[7], v[6], v[3], v[2], v[1]});
	endtask
	task automatic util(input logic [31:0] a, input logic w,
		input logic [31:0] ea, input logic [5:0] ef);
		@(posedge sys_clk);
		util_addr <= a;
		util_write <= w;
		@(posedge sys_clk);
		#1;
		check("util_addr", util_mem_addr, ea);
		check("util_flags", {26'h0, util_read_ok, util_hit,
			mem_parity_force}, {26'h0, ef});
	endtask
	// Grant searched for a bounded six cycles after the take
	task automatic vme(input logic [1:0] sp, input logic [31:0] a,
		input logic [3:0] m, input logic g, input logic [31:0] ea,
		input logic [2:0] ec);
		logic seen;
		logic [31:0] ma;
		logic [2:0] ac;
		seen = 1'b0;
		ma = 32'h0;
		ac = 3'h0;
		i_vme_master_model.access(sp, a, m);
		for (int i = 0; i < 6; i++)
		begin
			@(posedge sys_clk);
			#1;
			if (!seen && vme_grant === 1'b1)
			begin
				seen = 1'b1;
				ma = vme_mbus_addr;
				ac = vme_access;
			end
		end
		check("grant", {31'h0, seen}, {31'h0, g});
		if (g)
		begin
			check("mbus_addr", ma, ea);
			check("access", {29'h0, ac}, {29'h0, ec});
		end
	endtask
	task automatic do_reset;
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
	endtask
	task final_report;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ==========================================================
	// Main sequence
	initial
	begin
		{n_fail, n_tests, cycles} = '0;
		{rst_n, reg_sel, reg_write, util_write} = '0;
		reg_byte_en = 4'hF;
		{reg_addr, reg_wdata, util_addr} = '0;
		ra = '{ADDR_DIAG_STATUS, ADDR_PARITY_ERR, ADDR_CPU_CONFIG,
			ADDR_DIAG_CONTROL, ADDR_VME_UPPER, 32'hFFF84100,
			ADDR_DIAG_STATUS_S, ADDR_PARITY_ERR_S, ADDR_DIAG_CONTROL_S};
		rx = '{32'h12345678, 32'h0BAD0C40, 32'h5A5A0003, 32'h0, 32'h0,
			32'h0, 32'h0, 32'h0, 32'h0};
		rs = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h12345678,
			32'h0BAD0C40, 32'h0};
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		ctl(9'h000);
		util(32'hFFC01234, 1'b1, 32'h00001234, 6'h10);
		// Readable, write-only and unmapped places
		for (k = 0; k < 9; k++)
		begin
			bus(1'b0, ra[k], 32'h0, 4'hF);
			check("rdata", rd, rx[k]);
			check("rdata_small", rds, rs[k]);
			check("error", {31'h0, er}, 32'h0);
		end
		bus(1'b1, ADDR_VME_UPPER, 32'hFFFFFFA5, 4'hF);
		bus(1'b0, ADDR_VME_UPPER, 32'h0, 4'hF);
		check("upper_read", rd, 32'h0);
		vme(SPACE_A24, 32'hFF123456, 4'hF, 1'b1, 32'hA5123456, 3'h0);
		vme(SPACE_A32, 32'h87654321, 4'h9, 1'b1, 32'h87654321, 3'h5);
		vme(SPACE_A16, 32'h00001234, 4'hD, 1'b0, 32'h0, 3'h0);
		vme(SPACE_A32, 32'h00400010, 4'hE, 1'b1, 32'h00400010, 3'h1);
		vme(SPACE_A32, 32'h00400020, 4'hD, 1'b1, 32'h00400020, 3'h2);
		vme(SPACE_A32, 32'h00400030, 4'hB, 1'b1, 32'h00400030, 3'h3);
		vme(SPACE_A32, 32'h00400040, 4'hA, 1'b1, 32'h00400040, 3'h4);
		// All settable bits on except the board reset
		bus(1'b1, ADDR_DIAG_CONTROL, 32'hFFFFFFFE, 4'hF);
		ctl(9'h1FE);
		util(32'hFFC01234, 1'b1, 32'hFFC01234, 6'h3F);
		util(32'hFFC05678, 1'b0, 32'hFFC05678, 6'h30);
		util(32'h00001234, 1'b0, 32'h00001234, 6'h20);
		// Smaller-station control address reaches only that map
		bus(1'b1, ADDR_DIAG_CONTROL_S, 32'h00000040, 4'hF);
		@(posedge sys_clk);
		#1;
		check("kbd_small", {31'h0, kbd_small}, 32'h1);
		// Partial word refused, nothing changes
		bus(1'b1, ADDR_DIAG_CONTROL, 32'h0, 4'h3);
		check("error", {31'h0, er}, 32'h1);
		ctl(9'h1FE);
		// Board reset request must give exactly one pulse
		bus(1'b1, ADDR_DIAG_CONTROL, 32'h00000001, 4'hF);
		k = 0;
		repeat (5)
		begin
			@(posedge sys_clk);
			#1;
			k = k + (board_reset_trigger === 1'b1);
		end
		check("trigger_pulses", k, 32'h1);
		// Mid-run reset clears set bits but keeps the upper address
		bus(1'b1, ADDR_DIAG_CONTROL, 32'h000001FE, 4'hF);
		do_reset();
		ctl(9'h000);
		vme(SPACE_A24, 32'h00ABCDEF, 4'h9, 1'b1, 32'hA5ABCDEF, 3'h5);
		final_report();
	end
endmodule
